// >>> bench/aeu_mem_model.sv
// behavioural code and data memory answering the sequencer's reads
`timescale 1ns/10ps
module aeu_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [logic [15:0]];

  initial mem_rdata = 8'h00;

  task automatic load(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask

  // data stands one cycle only; then the inverse shows, so a late sample is caught
  always @(posedge clk) begin
    if (mem_rd === 1'b1) begin
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : (mem_addr[7:0] ^ 8'h5a);
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // aeu_mem_model

// >>> bench/aeu_top_tb.sv
// self-checking bench for the addressing-mode sequencer
`timescale 1ns/10ps
module aeu_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic [3:0]  mode = 4'h0;
  logic [7:0]  pfx = 8'h00;
  logic        so = 1'b0;
  logic [15:0] pc = 16'h0000;
  logic [7:0]  xr = 8'h00;
  logic [7:0]  yr = 8'h00;
  logic        mset = 1'b0;
  logic        mclr = 1'b0;
  logic        rd, busy, done, ill;
  logic [15:0] addr, ea, npc, tgt;
  logic [7:0]  rdata, opnd;
  logic [1:0]  len, imask;
  int          bad_count = 0;
  int          n_compared = 0;
  int          reads = 0;
  int          cycles = 0;
  int          lat = 0;
  int          r0 = 0;

  always #50 clk = ~clk;

  aeu_top dut (
    .REF_CLK(clk), .RST(rst), .START(start), .MODE(mode), .PREFIX(pfx),
    .SHORT_ONLY(so), .PC(pc), .X_REG(xr), .Y_REG(yr), .MASK_SET(mset),
    .MASK_CLR(mclr), .MEM_RD(rd), .MEM_ADDR(addr), .MEM_RDATA(rdata),
    .BUSY(busy), .DONE(done), .ILLEGAL(ill), .EA(ea), .OPERAND(opnd),
    .INSTR_LEN(len), .NEXT_PC(npc), .BRANCH_TARGET(tgt), .INT_MASK(imask)
  );

  aeu_mem_model mem_i (.clk(clk), .mem_rd(rd), .mem_addr(addr), .mem_rdata(rdata));

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a hang costs a mismatch rather than an endless run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rd === 1'b1) reads <= reads + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic go(input logic [3:0] m, input logic [7:0] p, input logic s,
                    input logic [15:0] a, input logic [7:0] x, input logic [7:0] y);
    @(posedge clk);
    start <= 1'b1;
    mode <= m;
    pfx <= p;
    so <= s;
    pc <= a;
    xr <= x;
    yr <= y;
    @(posedge clk);
    start <= 1'b0;
    #1;
    r0 = reads;
    // the cycle in which START stood counts as the first
    lat = 1;
    do begin
      @(posedge clk);
      #1;
      lat++;
    end while (done !== 1'b1 && lat < 20);
  endtask

  // latency is two cycles plus two per memory read
  task automatic basic(input int e_lat, input logic e_ill);
    chk(16'(lat), 16'(e_lat));
    chk(16'(reads - r0), 16'((e_lat - 2) / 2));
    chk({15'h0000, ill}, {15'h0000, e_ill});
  endtask

  task automatic res(input logic [1:0] n, input int e_lat, input logic [15:0] e_ea,
                     input logic [7:0] e_op, input logic k_op);
    basic(e_lat, 1'b0);
    chk({14'h0000, len}, {14'h0000, n});
    chk(npc, pc + {14'h0000, n});
    chk(ea, e_ea);
    if (k_op) chk({8'h00, opnd}, {8'h00, e_op});
  endtask

  task automatic rel(input logic [15:0] e_tgt, input logic [7:0] e_op, input int e_lat);
    basic(e_lat, 1'b0);
    chk({14'h0000, len}, 16'h0002);
    chk({8'h00, opnd}, {8'h00, e_op});
    chk(tgt, e_tgt);
  endtask

  task automatic t_direct();
    go(aeu_pkg::M_INHERENT, aeu_pkg::PFX_NONE, 1'b0, 16'h0200, 8'h00, 8'h00);
    basic(2, 1'b0);
    chk({14'h0000, len}, 16'h0001);
    mem_i.load(16'h0301, 8'h55);
    go(aeu_pkg::M_IMMEDIATE, aeu_pkg::PFX_NONE, 1'b0, 16'h0300, 8'h00, 8'h00);
    basic(4, 1'b0);
    chk({8'h00, opnd}, 16'h0055);
    chk({14'h0000, len}, 16'h0002);
    mem_i.load(16'h0311, 8'h9c);
    go(aeu_pkg::M_DIR_S, aeu_pkg::PFX_NONE, 1'b0, 16'h0310, 8'h00, 8'h00);
    res(2'h2, 4, 16'h009c, 8'h9c, 1'b1);
    mem_i.load(16'h0321, 8'h12);
    mem_i.load(16'h0322, 8'h34);
    go(aeu_pkg::M_DIR_L, aeu_pkg::PFX_NONE, 1'b0, 16'h0320, 8'h00, 8'h00);
    res(2'h3, 6, 16'h1234, 8'h00, 1'b0);
  endtask

  task automatic t_indexed();
    go(aeu_pkg::M_IDX_0, aeu_pkg::PFX_NONE, 1'b0, 16'h0330, 8'hff, 8'h00);
    res(2'h1, 2, 16'h00ff, 8'h00, 1'b0);
    mem_i.load(16'h0341, 8'hff);
    go(aeu_pkg::M_IDX_S, aeu_pkg::PFX_NONE, 1'b0, 16'h0340, 8'hff, 8'h00);
    res(2'h2, 4, 16'h01fe, 8'hff, 1'b1);
    mem_i.load(16'h0351, 8'hff);
    mem_i.load(16'h0352, 8'hf0);
    go(aeu_pkg::M_IDX_L, aeu_pkg::PFX_SECOND_IX, 1'b0, 16'h0350, 8'h01, 8'h20);
    res(2'h3, 6, 16'h0010, 8'h00, 1'b0);
  endtask

  task automatic t_indirect();
    mem_i.load(16'h0361, 8'h40);
    mem_i.load(16'h0040, 8'ha5);
    go(aeu_pkg::M_IND_S, aeu_pkg::PFX_NONE, 1'b0, 16'h0360, 8'h00, 8'h00);
    res(2'h2, 6, 16'h00a5, 8'h00, 1'b0);
    mem_i.load(16'h0371, 8'hff);
    mem_i.load(16'h00ff, 8'hab);
    mem_i.load(16'h0100, 8'hcd);
    go(aeu_pkg::M_IND_L, aeu_pkg::PFX_NONE, 1'b0, 16'h0370, 8'h00, 8'h00);
    res(2'h2, 8, 16'habcd, 8'h00, 1'b0);
    mem_i.load(16'h03b1, 8'h60);
    mem_i.load(16'h0060, 8'h80);
    mem_i.load(16'h0061, 8'h00);
    go(aeu_pkg::M_INDIDX_L, aeu_pkg::PFX_NONE, 1'b0, 16'h03b0, 8'h03, 8'h00);
    res(2'h2, 8, 16'h8003, 8'h00, 1'b0);
  endtask

  task automatic t_prefix();
    mem_i.load(16'h0381, 8'h41);
    mem_i.load(16'h0041, 8'h07);
    go(aeu_pkg::M_DIR_S, aeu_pkg::PFX_INDIRECT, 1'b0, 16'h0380, 8'h00, 8'h00);
    res(2'h2, 6, 16'h0007, 8'h00, 1'b0);
    mem_i.load(16'h0391, 8'h50);
    mem_i.load(16'h0050, 8'hff);
    go(aeu_pkg::M_IDX_S, aeu_pkg::PFX_INDIRECT, 1'b0, 16'h0390, 8'hff, 8'h00);
    res(2'h2, 6, 16'h01fe, 8'h00, 1'b0);
    mem_i.load(16'h03a1, 8'h51);
    mem_i.load(16'h0051, 8'h22);
    go(aeu_pkg::M_IDX_S, aeu_pkg::PFX_IND_SECOND, 1'b0, 16'h03a0, 8'h00, 8'h10);
    res(2'h2, 6, 16'h0032, 8'h00, 1'b0);
  endtask

  task automatic t_class();
    logic [3:0] lm [4] = '{aeu_pkg::M_DIR_L, aeu_pkg::M_IDX_L, aeu_pkg::M_IND_L,
                           aeu_pkg::M_INDIDX_L};
    foreach (lm[i]) begin
      go(lm[i], aeu_pkg::PFX_NONE, 1'b1, 16'h0400, 8'h01, 8'h02);
      basic(2, 1'b1);
    end
    go(aeu_pkg::M_IDX_S, aeu_pkg::PFX_INDIRECT, 1'b1, 16'h0390, 8'hff, 8'h00);
    res(2'h2, 6, 16'h01fe, 8'h00, 1'b0);
    go(aeu_pkg::M_DIR_S, aeu_pkg::PFX_NONE, 1'b1, 16'h0310, 8'h00, 8'h00);
    res(2'h2, 4, 16'h009c, 8'h9c, 1'b1);
  endtask

  task automatic t_relative();
    mem_i.load(16'h1001, 8'h80);
    go(aeu_pkg::M_REL_D, aeu_pkg::PFX_NONE, 1'b0, 16'h1000, 8'h00, 8'h00);
    rel(16'h0f82, 8'h80, 4);
    mem_i.load(16'h1011, 8'h7f);
    go(aeu_pkg::M_REL_D, aeu_pkg::PFX_NONE, 1'b0, 16'h1010, 8'h00, 8'h00);
    rel(16'h1091, 8'h7f, 4);
    mem_i.load(16'h1021, 8'h30);
    mem_i.load(16'h0030, 8'hfe);
    go(aeu_pkg::M_REL_I, aeu_pkg::PFX_NONE, 1'b0, 16'h1020, 8'h00, 8'h00);
    rel(16'h1020, 8'hfe, 6);
    go(aeu_pkg::M_REL_D, aeu_pkg::PFX_INDIRECT, 1'b0, 16'h1020, 8'h00, 8'h00);
    rel(16'h1020, 8'hfe, 6);
  endtask

  task automatic pulse(input logic s, input logic c);
    @(posedge clk);
    mset <= s;
    mclr <= c;
    @(posedge clk);
    mset <= 1'b0;
    mclr <= 1'b0;
    #1;
  endtask

  task automatic t_mask();
    pulse(1'b0, 1'b1);
    chk({14'h0000, imask}, 16'h0000);
    pulse(1'b1, 1'b0);
    chk({14'h0000, imask}, 16'h0003);
    pulse(1'b0, 1'b1);
    pulse(1'b1, 1'b1);
    chk({14'h0000, imask}, 16'h0003);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({14'h0000, imask}, 16'h0003);
    chk(npc, 16'h0001);
    chk({14'h0000, busy, done}, 16'h0000);
    t_direct();
    t_indexed();
    t_indirect();
    t_prefix();
    t_class();
    t_relative();
    t_mask();
    conclude();
  end
endmodule // aeu_top_tb

// >>> design/aeu_ea_calc.sv
// effective-address and branch-target adder
`timescale 1ns/10ps
module aeu_ea_calc (
  aeu_calc_if.calc c
);
  // unsigned index sum; wraps within the 64 Kbyte space
  assign c.ea     = c.add_index ? c.value + {8'h00, c.index} : c.value;
  // offset is sign-extended before it meets the next pc
  assign c.target = c.pc_next + {{8{c.rel_off[7]}}, c.rel_off};
endmodule // aeu_ea_calc

// >>> design/aeu_top.sv
// addressing-mode sequencer: operand fetch, pointer fetch, effective address
`timescale 1ns/10ps
module aeu_top (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        START,
  input  wire logic [3:0]  MODE,
  input  wire logic [7:0]  PREFIX,
  input  wire logic        SHORT_ONLY,
  input  wire logic [15:0] PC,
  input  wire logic [7:0]  X_REG,
  input  wire logic [7:0]  Y_REG,
  input  wire logic        MASK_SET,
  input  wire logic        MASK_CLR,
  output logic             MEM_RD,
  output logic [15:0]      MEM_ADDR,
  input  wire logic [7:0]  MEM_RDATA,
  output logic             BUSY,
  output logic             DONE,
  output logic             ILLEGAL,
  output logic [15:0]      EA,
  output logic [7:0]       OPERAND,
  output logic [1:0]       INSTR_LEN,
  output logic [15:0]      NEXT_PC,
  output logic [15:0]      BRANCH_TARGET,
  output logic [1:0]       INT_MASK
);

  typedef struct packed {
    aeu_pkg::aeu_state_type st;
    aeu_pkg::aeu_mode_type  mode;
    logic                   pend;
    logic [15:0]            addr;
    logic [15:0]            pc;
    logic [7:0]             idx;
    logic [7:0]             b1;
    logic [7:0]             b2;
    logic [1:0]             len;
    logic                   done;
    logic                   illegal;
    logic [15:0]            ea;
    logic [15:0]            target;
    logic [1:0]             mask;
  } aeu_regs_type;

  aeu_regs_type s_q;
  aeu_regs_type s_d;
  aeu_pkg::aeu_mode_type m_in;
  aeu_pkg::aeu_mode_type m_eff;
  logic                  y_eff;
  logic                  long_mode;
  logic                  word_val;

  aeu_calc_if calc_c ();

  aeu_ea_calc u_calc (
    .c (calc_c)
  );

  // bytes that follow the opcode for each mode
  function automatic logic [1:0] opnd_bytes(input aeu_pkg::aeu_mode_type m);
    case (m)
      aeu_pkg::M_INHERENT, aeu_pkg::M_IDX_0: opnd_bytes = 2'h0;
      aeu_pkg::M_DIR_L, aeu_pkg::M_IDX_L:    opnd_bytes = 2'h2;
      default:                               opnd_bytes = 2'h1;
    endcase
  endfunction

  assign m_in = aeu_pkg::aeu_mode_type'(MODE);

  always_comb begin
    m_eff = m_in;
    y_eff = 1'b0;
    case (PREFIX)
      aeu_pkg::PFX_SECOND_IX: begin
        y_eff = 1'b1;
      end
      aeu_pkg::PFX_INDIRECT, aeu_pkg::PFX_IND_SECOND: begin
        y_eff = (PREFIX == aeu_pkg::PFX_IND_SECOND);
        case (m_in)
          aeu_pkg::M_DIR_S: m_eff = aeu_pkg::M_IND_S;
          aeu_pkg::M_DIR_L: m_eff = aeu_pkg::M_IND_L;
          aeu_pkg::M_IDX_S: m_eff = aeu_pkg::M_INDIDX_S;
          aeu_pkg::M_IDX_L: m_eff = aeu_pkg::M_INDIDX_L;
          aeu_pkg::M_REL_D: m_eff = aeu_pkg::M_REL_I;
          default:          m_eff = m_in;
        endcase
      end
      default: begin
        y_eff = 1'b0;
      end
    endcase
  end

  // long forms that short-only instructions refuse
  assign long_mode = (m_eff == aeu_pkg::M_DIR_L) || (m_eff == aeu_pkg::M_IDX_L) ||
                     (m_eff == aeu_pkg::M_IND_L) || (m_eff == aeu_pkg::M_INDIDX_L);

  // word pointers and operands are high byte first
  assign word_val = (s_q.mode == aeu_pkg::M_DIR_L) || (s_q.mode == aeu_pkg::M_IDX_L) ||
                    (s_q.mode == aeu_pkg::M_IND_L) || (s_q.mode == aeu_pkg::M_INDIDX_L);

  // index added only in indexed forms
  assign calc_c.value     = word_val ? {s_q.b1, s_q.b2} : {aeu_pkg::ZERO_PAGE, s_q.b1};
  assign calc_c.index     = s_q.idx;
  assign calc_c.add_index = (s_q.mode == aeu_pkg::M_IDX_S) ||
                            (s_q.mode == aeu_pkg::M_IDX_L) ||
                            (s_q.mode == aeu_pkg::M_INDIDX_S) ||
                            (s_q.mode == aeu_pkg::M_INDIDX_L);
  assign calc_c.pc_next   = s_q.pc + {14'h0000, s_q.len};
  assign calc_c.rel_off   = s_q.b1;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (MASK_SET) begin
      s_d.mask = aeu_pkg::MASK_LEVEL_SET;
    end else if (MASK_CLR) begin
      s_d.mask = aeu_pkg::MASK_LEVEL_CLR;
    end
    case (s_q.st)
      aeu_pkg::S_IDLE: begin
        if (START) begin
          s_d.mode    = m_eff;
          s_d.idx     = y_eff ? Y_REG : X_REG;
          s_d.pc      = PC;
          s_d.addr    = PC + 16'h0001;
          s_d.b1      = 8'h00;
          s_d.b2      = 8'h00;
          s_d.pend    = 1'b0;
          s_d.len     = aeu_pkg::LEN_OPCODE + opnd_bytes(m_eff);
          s_d.illegal = SHORT_ONLY && long_mode;
          if ((opnd_bytes(m_eff) == 2'h0) || (SHORT_ONLY && long_mode)) begin
            s_d.st = aeu_pkg::S_FINISH;
          end else begin
            s_d.st = aeu_pkg::S_OPND1;
          end
        end
      end
      aeu_pkg::S_OPND1: begin
        if (!s_q.pend) begin
          s_d.pend = 1'b1;
        end else begin
          s_d.pend = 1'b0;
          s_d.b1   = MEM_RDATA;
          if (s_q.mode == aeu_pkg::M_DIR_L || s_q.mode == aeu_pkg::M_IDX_L) begin
            s_d.addr = s_q.addr + 16'h0001;
            s_d.st   = aeu_pkg::S_OPND2;
          end else if (s_q.mode == aeu_pkg::M_IND_S || s_q.mode == aeu_pkg::M_IND_L ||
                       s_q.mode == aeu_pkg::M_INDIDX_S ||
                       s_q.mode == aeu_pkg::M_INDIDX_L || s_q.mode == aeu_pkg::M_REL_I) begin
            s_d.addr = {aeu_pkg::ZERO_PAGE, MEM_RDATA};
            s_d.st   = aeu_pkg::S_PTR1;
          end else begin
            s_d.st = aeu_pkg::S_FINISH;
          end
        end
      end
      aeu_pkg::S_OPND2: begin
        if (!s_q.pend) begin
          s_d.pend = 1'b1;
        end else begin
          s_d.pend = 1'b0;
          s_d.b2   = MEM_RDATA;
          s_d.st   = aeu_pkg::S_FINISH;
        end
      end
      aeu_pkg::S_PTR1: begin
        if (!s_q.pend) begin
          s_d.pend = 1'b1;
        end else begin
          s_d.pend = 1'b0;
          s_d.b1   = MEM_RDATA;
          // word pointer needs a second read
          if (s_q.mode == aeu_pkg::M_IND_L || s_q.mode == aeu_pkg::M_INDIDX_L) begin
            s_d.addr = s_q.addr + 16'h0001;
            s_d.st   = aeu_pkg::S_PTR2;
          end else begin
            s_d.st = aeu_pkg::S_FINISH;
          end
        end
      end
      aeu_pkg::S_PTR2: begin
        if (!s_q.pend) begin
          s_d.pend = 1'b1;
        end else begin
          s_d.pend = 1'b0;
          s_d.b2   = MEM_RDATA;
          s_d.st   = aeu_pkg::S_FINISH;
        end
      end
      aeu_pkg::S_FINISH: begin
        s_d.ea     = (s_q.mode == aeu_pkg::M_IDX_0) ? {aeu_pkg::ZERO_PAGE, s_q.idx}
                                                     : calc_c.ea;
        s_d.target = calc_c.target;
        s_d.done   = 1'b1;
        s_d.st     = aeu_pkg::S_IDLE;
      end
      default: begin
        s_d.st = aeu_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s_q         <= '0;
      s_q.st      <= aeu_pkg::S_IDLE;
      s_q.mode    <= aeu_pkg::M_INHERENT;
      s_q.addr    <= aeu_pkg::ADDR_RESET;
      s_q.len     <= aeu_pkg::LEN_OPCODE;
      s_q.mask    <= aeu_pkg::MASK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // a read is requested once, data is taken the following cycle
  assign MEM_RD        = (s_q.st != aeu_pkg::S_IDLE) && (s_q.st != aeu_pkg::S_FINISH) &&
                         !s_q.pend;
  assign MEM_ADDR      = s_q.addr;
  assign BUSY          = (s_q.st != aeu_pkg::S_IDLE);
  assign DONE          = s_q.done;
  assign ILLEGAL       = s_q.illegal;
  assign EA            = s_q.ea;
  assign OPERAND       = s_q.b1;
  assign INSTR_LEN     = s_q.len;
  assign NEXT_PC       = calc_c.pc_next;
  assign BRANCH_TARGET = s_q.target;
  assign INT_MASK      = s_q.mask;

  AST_INHERENT_ONE_BYTE: assert property (@(posedge REF_CLK) disable iff (RST)
    START && !BUSY && m_in == aeu_pkg::M_INHERENT |-> !MEM_RD ##2 DONE && INSTR_LEN == 2'h1)
    else $error("inherent instruction not one byte");

  AST_IMMEDIATE_LEN: assert property (@(posedge REF_CLK) disable iff (RST)
    DONE && s_q.mode == aeu_pkg::M_IMMEDIATE |-> INSTR_LEN == 2'h2 && OPERAND == $past(OPERAND))
    else $error("immediate length wrong");

  AST_SHORT_DIRECT_PAGE0: assert property (@(posedge REF_CLK) disable iff (RST)
    DONE && s_q.mode == aeu_pkg::M_DIR_S |-> EA[15:8] == 8'h00 && EA[7:0] == OPERAND)
    else $error("short direct outside page zero");

  AST_LONG_DIRECT_TWO_READS: assert property (@(posedge REF_CLK) disable iff (RST)
    START && !BUSY && m_eff == aeu_pkg::M_DIR_L && !SHORT_ONLY
    |=> MEM_RD ##2 MEM_RD && MEM_ADDR == $past(MEM_ADDR, 2) + 16'h0001 ##3 DONE)
    else $error("long direct fetch sequence wrong");

  AST_INDEX_SUM: assert property (@(posedge REF_CLK) disable iff (RST)
    DONE && s_q.mode == aeu_pkg::M_IDX_S |-> EA == {8'h00, s_q.b1} + {8'h00, s_q.idx})
    else $error("indexed sum wrong");

  AST_NO_OFFSET_INDEX: assert property (@(posedge REF_CLK) disable iff (RST)
    DONE && s_q.mode == aeu_pkg::M_IDX_0 |-> EA == {8'h00, s_q.idx} && INSTR_LEN == 2'h1)
    else $error("no-offset indexed wrong");

  AST_SHORT_INDEX_RANGE: assert property (@(posedge REF_CLK) disable iff (RST)
    DONE && s_q.mode == aeu_pkg::M_IDX_S |-> EA <= 16'h01fe)
    else $error("short indexed beyond 1fe");

  AST_POINTER_PAGE0: assert property (@(posedge REF_CLK) disable iff (RST)
    MEM_RD && s_q.st == aeu_pkg::S_PTR1 |-> MEM_ADDR[15:8] == 8'h00)
    else $error("pointer read outside page zero");

  AST_REL_TARGET: assert property (@(posedge REF_CLK) disable iff (RST)
    DONE && s_q.mode == aeu_pkg::M_REL_D
    |-> BRANCH_TARGET == s_q.pc + 16'h0002 + {{8{s_q.b1[7]}}, s_q.b1})
    else $error("relative target wrong");

  AST_SHORT_ONLY_REFUSE: assert property (@(posedge REF_CLK) disable iff (RST)
    START && !BUSY && SHORT_ONLY && long_mode |-> !MEM_RD ##2 DONE && ILLEGAL)
    else $error("long form not refused");

  AST_MASK_LEVEL: assert property (@(posedge REF_CLK) disable iff (RST)
    MASK_SET |=> INT_MASK == 2'h3)
    else $error("mask set not level 3");

endmodule // aeu_top

// >>> pkg/aeu_calc_if.sv
// carrier between the sequencer and the address adder
`timescale 1ns/10ps
interface aeu_calc_if;
  logic [15:0] value;
  logic [7:0]  index;
  logic        add_index;
  logic [15:0] pc_next;
  logic [7:0]  rel_off;
  logic [15:0] ea;
  logic [15:0] target;
  modport core (output value, output index, output add_index, output pc_next,
                output rel_off, input ea, input target);
  modport calc (input value, input index, input add_index, input pc_next,
                input rel_off, output ea, output target);
endinterface

// >>> pkg/aeu_pkg.sv
// constants and types shared by the addressing-mode unit
package aeu_pkg;
  localparam int         ADDR_W        = 16;
  localparam int         DATA_W        = 8;
  localparam int         MODE_W        = 4;
  // prefix bytes ahead of the opcode
  localparam logic [7:0] PFX_NONE      = 8'h00;
  localparam logic [7:0] PFX_SECOND_IX = 8'h90;
  localparam logic [7:0] PFX_IND_SECOND = 8'h91;
  localparam logic [7:0] PFX_INDIRECT  = 8'h92;
  // interrupt mask levels
  localparam logic [1:0] MASK_LEVEL_SET = 2'h3;
  localparam logic [1:0] MASK_LEVEL_CLR = 2'h0;
  localparam logic [1:0] MASK_RESET    = 2'h3;
  localparam logic [7:0] ZERO_PAGE     = 8'h00;
  localparam logic [15:0] ADDR_RESET   = 16'h0000;
  localparam logic [1:0] LEN_OPCODE    = 2'h1;

  typedef enum logic [MODE_W-1:0] {
    M_INHERENT, M_IMMEDIATE, M_DIR_S, M_DIR_L, M_IDX_0, M_IDX_S, M_IDX_L,
    M_IND_S, M_IND_L, M_INDIDX_S, M_INDIDX_L, M_REL_D, M_REL_I
  } aeu_mode_type;

  typedef enum logic [2:0] {
    S_IDLE, S_OPND1, S_OPND2, S_PTR1, S_PTR2, S_FINISH
  } aeu_state_type;
endpackage
